// ===== hw/mcu_top.v
/*
 * multichannel uart: host target, per channel tx/rx engines, fifos.
 * assumes one 40 MHz reference clock, synchronous host strobes, async rx lines.
 */
`include "mcu_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// fifo
// ****************************************
module mcu_fifo #(
  parameter W = 32,
  parameter D = 8,
  parameter AW = 3
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o,
  output wire [AW:0] count_o
);
  localparam [31:0] DEPTH = D;
  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_ready_i & out_valid_o;
  assign in_ready_o = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rp_q];
  assign count_o = cnt_q;
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
    if (srst_i) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push & ~pop) cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // mcu_fifo

// ****************************************
// one channel
// ****************************************
module mcu_chan (
  input wire ref_clk_i,
  input wire srst_i,
  input wire acc_i,
  input wire wr_i,
  input wire [5:0] reg_i,
  input wire [31:0] wdata_i,
  output reg [31:0] rdata_o,
  input wire rxd_i,
  output reg txd_o
);
  localparam [2:0] T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h2, T_PAR = 3'h3,
    T_STOP = 3'h4;
  localparam [2:0] R_MARK = 3'h0, R_HUNT = 3'h1, R_START = 3'h2, R_DATA = 3'h3,
    R_PAR = 3'h4, R_STOP = 3'h5;
  reg [31:0] ctrl_q, baud_q, cntlb_q, lvl_q, last_q, lastp_q;
  reg [23:0] eof_q;
  reg [3:0] err_q;
  wire wr_en = acc_i & wr_i;
  wire rd_en = acc_i & ~wr_i;
  wire tx_rst = srst_i | ctrl_q[`MCU_C_TXRST];
  wire rx_rst = srst_i | ctrl_q[`MCU_C_RXRST];
  wire [3:0] tx_cnt, txp_cnt, rx_cnt, rxp_cnt;
  wire tx_rdy, tx_v, txp_v, rx_rdy, rx_v, rxp_v;
  wire [31:0] tx_word, rx_word;
  wire [15:0] tx_desc, rx_desc;
  wire tx_pop, txp_pop;
  reg rpush_q, rppush_q;
  reg [31:0] rpush_d_q;
  reg [15:0] rppush_d_q;

  // ****************************************
  // fifos
  // ****************************************
  mcu_fifo #(.W(32), .D(`MCU_FIFO_DEPTH), .AW(`MCU_FIFO_AW)) u_txd (
    .ref_clk_i(ref_clk_i), .srst_i(tx_rst),
    .in_valid_i(wr_en & (reg_i == `MCU_R_DATA)), .in_ready_o(tx_rdy),
    .in_data_i(wdata_i), .out_valid_o(tx_v), .out_ready_i(tx_pop),
    .out_data_o(tx_word), .count_o(tx_cnt));
  mcu_fifo #(.W(16), .D(`MCU_FIFO_DEPTH), .AW(`MCU_FIFO_AW)) u_txp (
    .ref_clk_i(ref_clk_i), .srst_i(tx_rst),
    .in_valid_i(wr_en & (reg_i == `MCU_R_PKT)), .in_ready_o(),
    .in_data_i(wdata_i[15:0]), .out_valid_o(txp_v), .out_ready_i(txp_pop),
    .out_data_o(tx_desc), .count_o(txp_cnt));
  mcu_fifo #(.W(32), .D(`MCU_FIFO_DEPTH), .AW(`MCU_FIFO_AW)) u_rxd (
    .ref_clk_i(ref_clk_i), .srst_i(rx_rst),
    .in_valid_i(rpush_q), .in_ready_o(rx_rdy), .in_data_i(rpush_d_q),
    .out_valid_o(rx_v), .out_ready_i(rd_en & (reg_i == `MCU_R_DATA)),
    .out_data_o(rx_word), .count_o(rx_cnt));
  mcu_fifo #(.W(16), .D(`MCU_FIFO_DEPTH), .AW(`MCU_FIFO_AW)) u_rxp (
    .ref_clk_i(ref_clk_i), .srst_i(rx_rst),
    .in_valid_i(rppush_q), .in_ready_o(), .in_data_i(rppush_d_q),
    .out_valid_o(rxp_v), .out_ready_i(rd_en & (reg_i == `MCU_R_PKT)),
    .out_data_o(rx_desc), .count_o(rxp_cnt));

  // ****************************************
  // registers
  // ****************************************
  wire set_frm, set_par, set_brk;
  wire set_ovr = rpush_q & ~rx_rdy;
  wire [3:0] err_set = {set_brk, set_ovr, set_par, set_frm};
  wire stat_clr = wr_en & (reg_i == `MCU_R_STAT);
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_q <= 32'h0000_0000;
      baud_q <= 32'h0000_0000;
      cntlb_q <= 32'h0000_0000;
      lvl_q <= 32'h0000_0000;
      eof_q <= 24'h00_0000;
      err_q <= 4'h0;
      last_q <= 32'h0000_0000;
      lastp_q <= 32'h0000_0000;
    end else begin
      if (wr_en) begin
        case (reg_i)
          `MCU_R_CTRL: ctrl_q <= wdata_i;
          `MCU_R_EOF: eof_q <= wdata_i[23:0];
          `MCU_R_BAUD: baud_q <= wdata_i;
          `MCU_R_CNTLB: cntlb_q <= wdata_i;
          `MCU_R_LVL: lvl_q <= wdata_i;
          default: ;
        endcase
      end
      err_q <= (stat_clr ? 4'h0 : err_q) | err_set;
      if (rd_en & (reg_i == `MCU_R_DATA) & rx_v) last_q <= rx_word;
      if (rd_en & (reg_i == `MCU_R_PKT) & rxp_v) lastp_q <= {16'h0000, rx_desc};
    end
  end

  wire tx_idle;
  always @* begin
    case (reg_i)
      `MCU_R_CTRL: rdata_o = ctrl_q;
      `MCU_R_STAT: rdata_o = {24'h00_0000, tx_idle, rxp_v, ~tx_rdy, rx_v, err_q};
      `MCU_R_DATA: rdata_o = rx_v ? rx_word : last_q;
      `MCU_R_EOF: rdata_o = {8'h00, eof_q};
      `MCU_R_BAUD: rdata_o = baud_q;
      `MCU_R_CNTLB: rdata_o = cntlb_q;
      `MCU_R_LVL: rdata_o = lvl_q;
      `MCU_R_PKT: rdata_o = rxp_v ? {16'h0000, rx_desc} : lastp_q;
      `MCU_R_RXCNT: rdata_o = {12'h000, rxp_cnt, 12'h000, rx_cnt};
      `MCU_R_TXCNT: rdata_o = {12'h000, txp_cnt, 12'h000, tx_cnt};
      default: rdata_o = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // transmit baud and engine
  // ****************************************
  reg [15:0] tbc_q;
  reg ten_q;
  always @(posedge ref_clk_i) begin
    if (tx_rst | ~ctrl_q[`MCU_C_TXEN]) begin
      tbc_q <= 16'h0000;
      ten_q <= 1'b0;
    end else if (tbc_q + 16'h0001 >= baud_q[15:0]) begin
      tbc_q <= 16'h0000;
      ten_q <= 1'b1;
    end else begin
      tbc_q <= tbc_q + 16'h0001;
      ten_q <= 1'b0;
    end
  end

  reg [2:0] tst_q, tn_q;
  reg [7:0] tsh_q;
  reg [31:0] twrd_q;
  reg [1:0] tbi_q;
  reg [15:0] pcnt_q;
  reg thave_q, tline_q, tpar_q;
  wire tpkt = ctrl_q[`MCU_C_TXPKT];
  wire tlen8 = ctrl_q[`MCU_C_TXLEN8];
  wire tfetch = (tst_q == T_IDLE) & ~thave_q & ctrl_q[`MCU_C_TXEN];
  assign tx_pop = tfetch & tx_v & (~tpkt | (pcnt_q != 16'h0000));
  assign txp_pop = tfetch & tpkt & (pcnt_q == 16'h0000) & txp_v;
  assign tx_idle = (tst_q == T_IDLE) & ~thave_q;
  wire [31:0] tlane = twrd_q >> {tbi_q, 3'b000};
  wire [7:0] tbyte = tlen8 ? tlane[7:0] : {1'b0, tlane[6:0]};
  wire tlast_byte = ctrl_q[`MCU_C_TXONE] | (tbi_q == 2'h3) | (tpkt & (pcnt_q == 16'h0001));
  wire tlast_bit = (tn_q == (tlen8 ? 3'h7 : 3'h6));
  wire tend = ((tst_q == T_DATA) & tlast_bit & ~ctrl_q[`MCU_C_TXPAR]) | (tst_q == T_PAR);
  wire [2:0] tstop = ctrl_q[`MCU_C_TXSTOP2] ? T_STOP : T_IDLE;
  always @(posedge ref_clk_i) begin
    if (tx_rst) begin
      tst_q <= T_IDLE;
      tn_q <= 3'h0;
      tsh_q <= 8'h00;
      twrd_q <= 32'h0000_0000;
      tbi_q <= 2'h0;
      pcnt_q <= 16'h0000;
      thave_q <= 1'b0;
      tline_q <= 1'b1;
      tpar_q <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      txd_o <= tline_q & ~ctrl_q[`MCU_C_TXBRK];
      if (txp_pop) pcnt_q <= tx_desc;
      if (tx_pop) begin
        twrd_q <= tx_word;
        thave_q <= 1'b1;
      end
      if (ten_q) begin
        case (tst_q)
          T_IDLE: begin
            if (thave_q) begin
              tline_q <= 1'b0;
              tsh_q <= tbyte;
              tpar_q <= ctrl_q[`MCU_C_TXLVL] ? ctrl_q[`MCU_C_TXODD] :
                (^tbyte) ^ ctrl_q[`MCU_C_TXODD];
              tst_q <= T_START;
            end
          end
          T_START: begin
            tline_q <= tsh_q[0];
            tsh_q <= {1'b0, tsh_q[7:1]};
            tn_q <= 3'h0;
            tst_q <= T_DATA;
          end
          T_DATA: begin
            if (tlast_bit) begin
              tline_q <= ctrl_q[`MCU_C_TXPAR] ? tpar_q : 1'b1;
              tst_q <= ctrl_q[`MCU_C_TXPAR] ? T_PAR : tstop;
            end else begin
              tline_q <= tsh_q[0];
              tsh_q <= {1'b0, tsh_q[7:1]};
              tn_q <= tn_q + 3'h1;
            end
          end
          T_PAR: begin
            tline_q <= 1'b1;
            tst_q <= tstop;
          end
          T_STOP: tst_q <= T_IDLE;
          default: tst_q <= T_IDLE;
        endcase
        // stop bit starts: advance to next byte
        if (tend) begin
          if (tpkt) pcnt_q <= pcnt_q - 16'h0001;
          if (tlast_byte) begin
            thave_q <= 1'b0;
            tbi_q <= 2'h0;
          end else begin
            tbi_q <= tbi_q + 2'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // receive line conditioning and engine
  // ****************************************
  reg rs1_q, rs2_q, rs3_q, rf_q, rfp_q;
  reg [2:0] rst_q, rn_q;
  reg [15:0] rcnt_q;
  reg [7:0] rsh_q;
  reg rpar_q;
  reg [31:0] racc_q;
  reg [1:0] rbi_q;
  reg [11:0] rbytes_q;
  reg [3:0] rperr_q;
  reg [23:0] gap_q;
  wire [15:0] rrate = baud_q[31:16];
  wire [15:0] rreload = (rrate == 16'h0000) ? 16'h0000 : rrate - 16'h0001;
  wire rlen8 = ctrl_q[`MCU_C_RXLEN8];
  wire [7:0] rbyte = rlen8 ? rsh_q : {1'b0, rsh_q[7:1]};
  wire rtick = (rcnt_q == 16'h0000);
  wire rstop = (rst_q == R_STOP) & rtick;
  wire rperr = ctrl_q[`MCU_C_RXPAR] & (ctrl_q[`MCU_C_RXLVL] ?
    (rpar_q != ctrl_q[`MCU_C_RXODD]) : ((^rbyte ^ rpar_q) != ctrl_q[`MCU_C_RXODD]));
  wire rzero = (rbyte == 8'h00) & ~(ctrl_q[`MCU_C_RXPAR] & rpar_q);
  assign set_brk = rstop & ~rf_q & rzero;
  assign set_frm = rstop & ~rf_q & ~rzero;
  assign set_par = rstop & rf_q & rperr;
  wire rgood = rstop & rf_q;
  wire [31:0] rnew = racc_q | ({24'h00_0000, rbyte} << {rbi_q, 3'b000});
  wire rpend = (rbytes_q != 12'h000);
  always @(posedge ref_clk_i) begin
    if (rx_rst) begin
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
      rs3_q <= 1'b1;
      rf_q <= 1'b1;
      rfp_q <= 1'b1;
      rst_q <= R_MARK;
      rn_q <= 3'h0;
      rcnt_q <= 16'h0000;
      rsh_q <= 8'h00;
      rpar_q <= 1'b0;
    end else begin
      rs1_q <= rxd_i;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
      if (rs2_q == rs3_q) rf_q <= rs2_q;
      rfp_q <= rf_q;
      if (~ctrl_q[`MCU_C_RXEN]) begin
        rst_q <= R_MARK;
        rcnt_q <= rreload;
      end else begin
        if (rst_q >= R_DATA && rf_q != rfp_q) rcnt_q <= rrate >> 1;
        else if (rtick) rcnt_q <= rreload;
        else rcnt_q <= rcnt_q - 16'h0001;
        case (rst_q)
          R_MARK: begin
            if (~rf_q) rcnt_q <= rreload;
            else if (rtick) rst_q <= R_HUNT;
          end
          R_HUNT: begin
            if (~rf_q) begin
              rcnt_q <= rrate >> 1;
              rst_q <= R_START;
            end
          end
          R_START: begin
            if (rtick) begin
              rst_q <= rf_q ? R_HUNT : R_DATA;
              rn_q <= 3'h0;
            end
          end
          R_DATA: begin
            if (rtick) begin
              rsh_q <= {rf_q, rsh_q[7:1]};
              rn_q <= rn_q + 3'h1;
              if (rn_q == (rlen8 ? 3'h7 : 3'h6)) begin
                rst_q <= ctrl_q[`MCU_C_RXPAR] ? R_PAR : R_STOP;
              end
            end
          end
          R_PAR: begin
            if (rtick) begin
              rpar_q <= rf_q;
              rst_q <= R_STOP;
            end
          end
          R_STOP: begin
            if (rtick) begin
              rst_q <= rf_q ? R_HUNT : R_MARK;
            end
          end
          default: rst_q <= R_MARK;
        endcase
      end
    end
  end

  // ****************************************
  // receive word building and descriptors
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (rx_rst) begin
      racc_q <= 32'h0000_0000;
      rbi_q <= 2'h0;
      rbytes_q <= 12'h000;
      rperr_q <= 4'h0;
      gap_q <= 24'h00_0000;
      rpush_q <= 1'b0;
      rpush_d_q <= 32'h0000_0000;
      rppush_q <= 1'b0;
      rppush_d_q <= 16'h0000;
    end else begin
      rpush_q <= 1'b0;
      rppush_q <= 1'b0;
      rperr_q <= rperr_q | err_set;
      if (rgood) begin
        gap_q <= 24'h00_0000;
        rbytes_q <= rbytes_q + 12'h001;
        if (ctrl_q[`MCU_C_RXONE]) begin
          rpush_q <= 1'b1;
          rpush_d_q <= {24'h00_0000, rbyte};
        end else if (rbi_q == 2'h3) begin
          rpush_q <= 1'b1;
          rpush_d_q <= rnew;
          racc_q <= 32'h0000_0000;
          rbi_q <= 2'h0;
        end else begin
          racc_q <= rnew;
          rbi_q <= rbi_q + 2'h1;
        end
      end else if (rpend & (gap_q > eof_q)) begin
        if (rbi_q != 2'h0) begin
          rpush_q <= 1'b1;
          rpush_d_q <= racc_q;
        end
        rppush_q <= ctrl_q[`MCU_C_RXPKT];
        rppush_d_q <= {rperr_q, rbytes_q};
        racc_q <= 32'h0000_0000;
        rbi_q <= 2'h0;
        rbytes_q <= 12'h000;
        rperr_q <= 4'h0;
        gap_q <= 24'h00_0000;
      end else if (rpend & (gap_q != 24'hFF_FFFF)) begin
        gap_q <= gap_q + 24'h00_0001;
      end
    end
  end
endmodule // mcu_chan

// ****************************************
// top: host target and channels
// ****************************************
module mcu_top (
  input wire ref_clk_i,
  input wire srst_i,
  input wire bus_req_i,
  input wire bus_wr_i,
  input wire [`MCU_AW-1:0] bus_addr_i,
  input wire [31:0] bus_wdata_i,
  output reg bus_ack_o,
  output reg [31:0] bus_rdata_o,
  input wire [7:0] switch_i,
  input wire [`MCU_NCH-1:0] rxd_i,
  output wire [`MCU_NCH-1:0] txd_o
);
  localparam [1:0] B_IDLE = 2'h0, B_DEC = 2'h1, B_WAIT = 2'h2;
  reg [1:0] bst_q;
  reg [`MCU_AW-1:0] addr_q;
  reg wr_q;
  reg [31:0] wdata_q;
  wire acc = (bst_q == B_WAIT);
  wire [`MCU_NCH-1:0] hit;
  wire [32*`MCU_NCH-1:0] ch_rdata;
  reg [31:0] rd_mux;
  integer i;

  genvar k;
  generate
    for (k = 0; k < `MCU_NCH; k = k + 1) begin : g_ch
      localparam [31:0] CB_FULL = `MCU_CH0_OFF + `MCU_CH_STRIDE * k;
      localparam [`MCU_AW-1:0] CB = CB_FULL[`MCU_AW-1:0];
      wire [`MCU_AW-1:0] rel = addr_q - CB;
      assign hit[k] = (addr_q >= CB) && (addr_q < CB + `MCU_CH_STRIDE);
      mcu_chan u_chan (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .acc_i(acc & hit[k]),
        .wr_i(wr_q),
        .reg_i(rel[5:0]),
        .wdata_i(wdata_q),
        .rdata_o(ch_rdata[32*k+31:32*k]),
        .rxd_i(rxd_i[k]),
        .txd_o(txd_o[k])
      );
    end
  endgenerate

  always @* begin
    rd_mux = 32'h0000_0000;
    if (addr_q == `MCU_BOARD_GP) begin
      rd_mux = {4'h0, `MCU_REV_MIN, `MCU_DESIGN_TYPE, `MCU_REV_MAJ, switch_i};
    end
    for (i = 0; i < `MCU_NCH; i = i + 1) begin
      if (hit[i]) rd_mux = ch_rdata[32*i +: 32];
    end
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      bst_q <= B_IDLE;
      addr_q <= {`MCU_AW{1'b0}};
      wr_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 32'h0000_0000;
    end else begin
      bus_ack_o <= 1'b0;
      case (bst_q)
        B_IDLE: begin
          if (bus_req_i) begin
            addr_q <= {bus_addr_i[`MCU_AW-1:2], 2'b00};
            wr_q <= bus_wr_i;
            wdata_q <= bus_wdata_i;
            bst_q <= B_DEC;
          end
        end
        B_DEC: bst_q <= B_WAIT;
        B_WAIT: begin
          bus_ack_o <= 1'b1;
          bus_rdata_o <= wr_q ? 32'h0000_0000 : rd_mux;
          bst_q <= B_IDLE;
        end
        default: bst_q <= B_IDLE;
      endcase
    end
  end
endmodule // mcu_top
`default_nettype wire

// ===== pkg/mcu_defines.vh
/*
 * register map, field positions and constants of the multichannel uart.
 * assumes inclusion by bare name from the design files.
 */
`ifndef MCU_DEFINES_VH
`define MCU_DEFINES_VH

// ****************************************
// host side map
// ****************************************
`define MCU_NCH 2
`define MCU_AW 12
`define MCU_CH0_OFF 12'h050
`define MCU_CH_STRIDE 12'h028
`define MCU_BOARD_GP 12'h004
`define MCU_BOARD_INT 12'h008
`define MCU_R_CTRL 6'h00
`define MCU_R_STAT 6'h04
`define MCU_R_DATA 6'h08
`define MCU_R_EOF 6'h0C
`define MCU_R_BAUD 6'h10
`define MCU_R_CNTLB 6'h14
`define MCU_R_LVL 6'h18
`define MCU_R_PKT 6'h1C
`define MCU_R_RXCNT 6'h20
`define MCU_R_TXCNT 6'h24

// ****************************************
// channel control fields
// ****************************************
`define MCU_C_TXRST 0
`define MCU_C_TXEN 2
`define MCU_C_RXEN 3
`define MCU_C_RXRST 12
`define MCU_C_TXBRK 13
`define MCU_C_TXPAR 16
`define MCU_C_TXODD 17
`define MCU_C_TXSTOP2 18
`define MCU_C_TXLEN8 19
`define MCU_C_RXPAR 20
`define MCU_C_RXODD 21
`define MCU_C_RXLEN8 23
`define MCU_C_TXPKT 24
`define MCU_C_TXONE 25
`define MCU_C_RXPKT 27
`define MCU_C_TXLVL 28
`define MCU_C_RXLVL 29
`define MCU_C_RXONE 30

// ****************************************
// status fields, identity and fifo sizing
// ****************************************
`define MCU_S_FRM 0
`define MCU_S_PAR 1
`define MCU_S_OVR 2
`define MCU_S_BRK 3
`define MCU_REV_MAJ 8'h01 // arbitrary value
`define MCU_REV_MIN 8'h01 // arbitrary value
`define MCU_DESIGN_TYPE 4'h3 // arbitrary value
`define MCU_FIFO_DEPTH 8
`define MCU_FIFO_AW 3

`endif

// ===== test/mcu_remote_uart.sv
/*
 * far-end uart on channel 0: sends frames, decodes the tx line.
 * assumes TBIT reference clocks per bit and the design's clock.
 */
`timescale 1ns/100ps
`default_nettype none
// ********
// remote uart
// ********
module mcu_remote_uart #(parameter int TBIT = 8) (
  input wire logic ref_clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic [9:0] got_q[$];
  int t_q[$];
  int nb = 8;
  int cyc = 0;
  initial line_o = 1'b1;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  // n bits lsb first, then two bit times marking
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_o = f[i];
      repeat (TBIT) @(posedge ref_clk_i);
      #1;
    end
    line_o = 1'b1;
    repeat (2 * TBIT) @(posedge ref_clk_i);
    #1;
  endtask
  // mid-bit capture of data, parity and stop
  always begin
    logic [9:0] w;
    @(negedge line_i);
    t_q.push_back(cyc);
    w = 10'h000;
    repeat (TBIT / 2) @(posedge ref_clk_i);
    for (int i = 0; i <= nb; i++) begin
      repeat (TBIT) @(posedge ref_clk_i);
      w[i] = line_i;
    end
    got_q.push_back(w);
  end
endmodule // mcu_remote_uart
`default_nettype wire

// ===== test/mcu_top_asserts.sv
/*
 * checker on the host target and serial tx pins of mcu_top.
 * assumes switch_i held steady and requests spaced as the target allows.
 */
`include "mcu_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// ********
// checker
// ********
module mcu_top_asserts (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic bus_req_i,
  input wire logic bus_wr_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic bus_ack_o,
  input wire logic [31:0] bus_rdata_o,
  input wire logic [7:0] switch_i,
  input wire logic [1:0] txd_o
);
  logic [1:0] cnt_q;
  logic take;
  // request accepted while the target is free
  assign take = bus_req_i && cnt_q <= 2'h1;
  always @(posedge ref_clk_i) begin
    if (srst_i) cnt_q <= 2'h0;
    else if (take) cnt_q <= 2'h3;
    else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  chk_ack_latency: assert property (take |-> ##3 bus_ack_o)
    else $error("ack not three cycles after request");
  chk_ack_single: assert property (bus_ack_o |=> !bus_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (bus_ack_o |-> $past(take, 3))
    else $error("ack without request");
  chk_write_zero: assert property (bus_ack_o && $past(bus_wr_i, 3) |-> bus_rdata_o == 32'h0)
    else $error("read data not zero after write");
  chk_rdata_hold: assert property (!bus_ack_o |-> $stable(bus_rdata_o))
    else $error("read data moved without ack");
  chk_unmapped_zero: assert property (take && !bus_wr_i && bus_addr_i >= 12'h0A0
    |-> ##3 bus_rdata_o == 32'h0) else $error("unmapped read not zero");
  chk_board_ident: assert property (take && !bus_wr_i && bus_addr_i[11:2] == 10'h001
    |-> ##3 bus_rdata_o == {4'h0, `MCU_REV_MIN, `MCU_DESIGN_TYPE, `MCU_REV_MAJ, switch_i})
    else $error("board word wrong");
  chk_line_idle: assert property ($fell(srst_i) |-> (txd_o == 2'h3) [*4])
    else $error("serial line not marking after reset");
  cover property (take && bus_wr_i);
  cover property (take && !bus_wr_i);
  cover property ($fell(txd_o[0]));
endmodule // mcu_top_asserts
bind mcu_top mcu_top_asserts u_chk (.ref_clk_i, .srst_i, .bus_req_i, .bus_wr_i, .bus_addr_i,
  .bus_ack_o, .bus_rdata_o, .switch_i, .txd_o);
`default_nettype wire

// ===== test/multichannel_uart_with_packet_fifos_bench.sv
/*
 * self-checking bench of mcu_top: host registers, channel 0 serial traffic.
 * assumes mcu_remote_uart on channel 0; channel 1 rx held at marking.
 */
`include "mcu_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// ********
// bench
// ********
module multichannel_uart_with_packet_fifos_bench;
  localparam int TBIT = 8;
  localparam logic [11:0] CH = `MCU_CH0_OFF;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic bus_req_i = 1'b0;
  logic bus_wr_i = 1'b0;
  logic [11:0] bus_addr_i = 12'h000;
  logic [31:0] bus_wdata_i = 32'h0;
  logic [7:0] switch_i = 8'h00;
  logic bus_ack_o;
  logic [31:0] bus_rdata_o;
  logic [1:0] txd_o;
  logic far_line;
  wire [1:0] rxd_i = {1'b1, far_line};
  logic [31:0] rd, w, c, seed = 32'h5;
  logic [31:0] cfg [5] = '{32'h4, 32'h90004, 32'hB0004, 32'h100B0004, 32'hC0004};
  logic [7:0] b, d, q[$];
  logic p, pe;
  int nd, n;
  int n_fail = 0, n_checks = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  mcu_top u_dut (.ref_clk_i, .srst_i, .bus_req_i, .bus_wr_i, .bus_addr_i, .bus_wdata_i,
    .bus_ack_o, .bus_rdata_o, .switch_i, .rxd_i, .txd_o);
  mcu_remote_uart #(.TBIT(TBIT)) u_far (.ref_clk_i, .line_i(txd_o[0]), .line_o(far_line));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  // one host access, answer left in rd
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] v);
    int k;
    bus_req_i = 1'b1;
    bus_wr_i = wr;
    bus_addr_i = a;
    bus_wdata_i = v;
    tick(1);
    bus_req_i = 1'b0;
    for (k = 0; bus_ack_o !== 1'b1; k++) begin
      if (k > 8) begin
        chk("ack", 1'b1, bus_ack_o);
        complete_run();
      end
      tick(1);
    end
    rd = bus_rdata_o;
  endtask
  task automatic rc(input string s, input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic pollst(input logic [7:0] m);
    rd = 32'h0;
    for (int k = 0; k < 40 && (rd[7:0] & m) == 8'h00; k++) acc(1'b0, CH + `MCU_R_STAT, 32'h0);
    if ((rd[7:0] & m) == 8'h00) begin
      chk("status poll", {24'h0, m}, rd & {24'h0, m});
      complete_run();
    end
  endtask
  task automatic flags(input logic [3:0] e);
    pollst(8'h0F);
    chk("status flags", e, rd[3:0]);
    c = rd & 32'hFFFFFFF0;
    acc(1'b1, CH + `MCU_R_STAT, 32'h0);
    rc("status cleared", CH + `MCU_R_STAT, c);
  endtask
  task automatic drain();
    for (int k = 0; k < 10; k++) begin
      acc(1'b0, CH + `MCU_R_STAT, 32'h0);
      if (rd[4]) acc(1'b0, CH + `MCU_R_DATA, 32'h0);
    end
  endtask
  initial begin
    tick(16);
    chk("txd in reset", 2'h3, txd_o);
    chk("ack in reset", 1'b0, bus_ack_o);
    srst_i = 1'b0;
    tick(1);
    w = rnd();
    switch_i = w[7:0];
    rc("board word", 12'h004, {4'h0, `MCU_REV_MIN, `MCU_DESIGN_TYPE, `MCU_REV_MAJ, w[7:0]});
    rc("irq summary", 12'h008, 32'h0);
    acc(1'b1, 12'h0A0, w);
    rc("unmapped", 12'h0A0, 32'h0);
    acc(1'b1, CH + `MCU_R_EOF, 32'hFFFFFFFF);
    acc(1'b1, CH + `MCU_CH_STRIDE + `MCU_R_EOF, w);
    rc("eof ch0", CH + `MCU_R_EOF, 32'h00FFFFFF);
    rc("eof ch1", CH + `MCU_CH_STRIDE + `MCU_R_EOF, w & 32'h00FFFFFF);
    acc(1'b1, CH + `MCU_R_BAUD, w);
    rc("baud", CH + `MCU_R_BAUD, w);
    acc(1'b1, CH + `MCU_R_BAUD, 32'h00080008);
    $display("registers done");
    for (int k = 0; k < 5; k++) begin
      c = cfg[k];
      nd = c[`MCU_C_TXLEN8] ? 8 : 7;
      pe = c[`MCU_C_TXPAR];
      u_far.nb = nd + pe;
      w = rnd();
      acc(1'b1, CH + `MCU_R_CTRL, c);
      acc(1'b1, CH + `MCU_R_DATA, w);
      for (n = 0; n < 600 && u_far.got_q.size() < 4; n++) tick(1);
      chk("tx chars", 4, u_far.got_q.size());
      if (u_far.got_q.size() < 4) complete_run();
      for (int i = 0; i < 4; i++) begin
        b = w[8*i +: 8];
        d = nd == 8 ? b : {1'b0, b[6:0]};
        p = c[`MCU_C_TXLVL] ? c[`MCU_C_TXODD] : ^d ^ c[`MCU_C_TXODD];
        chk("tx frame", (10'h1 << (nd + pe)) | ({9'h0, p & pe} << nd) | {2'b00, d},
          u_far.got_q[i]);
      end
      chk("tx spacing", TBIT * (2 + nd + pe + c[`MCU_C_TXSTOP2]),
        u_far.t_q[1] - u_far.t_q[0]);
      tick(3 * TBIT);
      u_far.got_q.delete();
      u_far.t_q.delete();
    end
    acc(1'b1, CH + `MCU_R_CTRL, 32'h00002004);
    tick(2);
    chk("tx break", 2'h2, txd_o);
    $display("transmit done");
    acc(1'b1, CH + `MCU_R_CTRL, 32'h40800008);
    tick(2 * TBIT);
    b = rnd();
    u_far.send({3'h7, b, 1'b0}, 10);
    pollst(8'h10);
    rc("rx byte", CH + `MCU_R_DATA, {24'h0, b});
    rc("rx reread", CH + `MCU_R_DATA, {24'h0, b});
    acc(1'b1, CH + `MCU_R_CTRL, 32'h40900008);
    b = rnd();
    u_far.send({2'h3, ~^b, b, 1'b0}, 11);
    flags(4'h2);
    rc("rx parity byte", CH + `MCU_R_DATA, {24'h0, b});
    acc(1'b1, CH + `MCU_R_CTRL, 32'h40800008);
    u_far.send({3'h0, b | 8'h01, 1'b0}, 10);
    flags(4'h1);
    drain();
    u_far.send(12'h000, 10);
    flags(4'h8);
    drain();
    b = rnd();
    u_far.send({3'h7, b, 1'b0}, 10);
    pollst(8'h10);
    rc("rx after resync", CH + `MCU_R_DATA, {24'h0, b});
    for (int i = 0; i < 9; i++) begin
      w = rnd();
      q.push_back(w[7:0]);
      u_far.send({3'h7, w[7:0], 1'b0}, 10);
    end
    flags(4'h4);
    for (int i = 0; i < 8; i++) rc("rx fifo", CH + `MCU_R_DATA, {24'h0, q[i]});
    rc("rx empty", CH + `MCU_R_DATA, {24'h0, q[7]});
    $display("receive done");
    complete_run();
  end
endmodule // multichannel_uart_with_packet_fifos_bench
`default_nettype wire
